// ### logic/burst_sequencer.sv
// two-bit wraparound burst address sequencer, interleaved or linear
module burst_sequencer
	import sram_cycle_pkg::*;
(
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  reset,
	// control
	input  wire logic                  load,
	input  wire logic                  advance,
	input  wire logic                  linear_mode,
	input  wire logic [BURST_BITS-1:0] base,
	// sequence output
	output logic      [BURST_BITS-1:0] seq
);

	typedef struct packed {
		logic [BURST_BITS-1:0] base;
		logic [BURST_BITS-1:0] count;
	} seq_state_t;

	seq_state_t state_reg;
	seq_state_t state_next;

	always_comb begin
		state_next = state_reg;
		if (load) begin
			state_next.base  = base;
			state_next.count = BURST_FIRST;
		end else if (advance) begin
			state_next.count = BURST_BITS'(state_reg.count + BURST_STEP);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// interleaved xors the count in, linear adds it with wraparound
	assign seq = linear_mode ? BURST_BITS'(state_reg.base + state_reg.count)
	                         : (state_reg.base ^ state_reg.count);

endmodule : burst_sequencer

// ### logic/sram_cycle_control.sv
// cycle decode, address and write-lane control of a flow-through burst sram
// Notes on behaviour
// - deselect on primary select high with controller strobe, or bad selects at a strobe
// - all selects active with processor strobe, or controller strobe and read: begin read
// - no strobe, advance low, read: continue read at next burst address
// - no strobe, advance high, read: suspend read, hold current address
// - no strobe, advance high, write after processor-strobe read: begin write at current address
// - selects active, controller strobe only, write indicated: begin write at external address
// - no strobe, advance low, write: continue write burst at next address
// - no strobe, advance high, write: suspend write, hold current address
// - sleep high overrides everything: no access, data pins floated
// - a processor-strobe access is always a read
// - writes only after a processor-strobe cycle or with controller strobe; the code writes in any open burst with a lane selected
// - output enable is unclocked and masked off during writes
// - in reads, drive data only with output enable active and device selected
// - wide organisation: lane inputs a to d pick bytes 0 to 3, any mix
// - narrow organisation: lanes a and b pick bytes 0 and 1 with parity
// - burst address from two-bit wrap counter, interleaved or linear by mode
// - unselected lanes stay unchanged during a byte write
// - sleep takes four clocks to enter or leave; pending accesses may drop
module sram_cycle_control
	import sram_cycle_pkg::*;
#(
	parameter bit WIDE_ORG = 1'b1,
	parameter int ADDR_W   = WIDE_ADDR_W
) (
	// clock and reset
	input  wire logic                          clk,
	input  wire logic                          reset,
	// asynchronous pins
	input  wire logic                          sleep_request,
	input  wire logic                          linear_burst,
	input  wire logic                          output_enable_n,
	// chip selects
	input  wire logic                          select_primary_n,
	input  wire logic                          select_secondary_high,
	input  wire logic                          select_tertiary_n,
	// address and burst control
	input  wire logic [ADDR_W-1:0]             address,
	input  wire logic                          proc_addr_strobe_n,
	input  wire logic                          ctrl_addr_strobe_n,
	input  wire logic                          burst_advance_n,
	// write controls
	input  wire logic                          global_write_n,
	input  wire logic                          byte_write_enable_n,
	input  wire logic                          lane_a_write_n,
	input  wire logic                          lane_b_write_n,
	input  wire logic                          lane_c_write_n,
	input  wire logic                          lane_d_write_n,
	// data and parity pins, split into input, output and enable
	input  wire logic [(WIDE_ORG ? WIDE_LANES : NARROW_LANES)*LANE_BITS-1:0] data_in,
	output logic      [(WIDE_ORG ? WIDE_LANES : NARROW_LANES)*LANE_BITS-1:0] data_out,
	output logic      [(WIDE_ORG ? WIDE_LANES : NARROW_LANES)*LANE_BITS-1:0] data_oe,
	// memory core
	output logic      [ADDR_W-1:0]             core_addr,
	output logic                               core_read,
	output logic                               core_write,
	output logic      [(WIDE_ORG ? WIDE_LANES : NARROW_LANES)-1:0] core_lane_we,
	output logic      [(WIDE_ORG ? WIDE_LANES : NARROW_LANES)*LANE_BITS-1:0] core_wdata,
	input  wire logic [(WIDE_ORG ? WIDE_LANES : NARROW_LANES)*LANE_BITS-1:0] core_rdata,
	// status
	output cycle_t                             cycle_type,
	output logic                               sleeping
);

	localparam int LANES  = WIDE_ORG ? WIDE_LANES : NARROW_LANES;
	localparam int DATA_W = LANES * LANE_BITS;

	generate
		if (ADDR_W <= BURST_BITS) begin : g_bad_addr
			$error("address width must exceed the burst counter width");
		end
		if (LANES > MAX_LANES) begin : g_bad_lanes
			$error("lane count exceeds available lane write inputs");
		end
	endgenerate

	typedef struct packed {
		logic [SYNC_STAGES-1:0] sleep_sync;
		logic [SYNC_STAGES-1:0] mode_sync;
		logic                   sleep_on;
		logic                   linear_on;
		cycle_t                 cycle;
		logic [ADDR_W-1:0]      addr;
		logic                   burst_open;
		logic                   after_proc_read;
		logic                   reading;
		logic                   core_wr;
		logic [LANES-1:0]       lane_we;
		logic [DATA_W-1:0]      wdata;
	} ctrl_state_t;

	ctrl_state_t state_reg;
	ctrl_state_t state_next;

	// lane inputs gathered, lane a lowest
	logic [MAX_LANES-1:0] lane_all_n;
	logic [LANES-1:0]     lane_n;
	logic [LANES-1:0]     lane_mask;
	logic                 write_ind;
	logic                 selects_ok;
	logic                 proc_start;
	logic                 ctrl_start;
	logic                 seq_load;
	logic                 seq_advance;
	logic [BURST_BITS-1:0] seq_low;

	assign lane_all_n = {lane_d_write_n, lane_c_write_n, lane_b_write_n, lane_a_write_n};
	assign lane_n     = lane_all_n[LANES-1:0];

	genvar lane;
	generate
		for (lane = 0; lane < LANES; lane++) begin : g_lane
			// each lane mask covers its data byte and its parity bit
			assign lane_mask[lane] = !global_write_n
			                       | (!byte_write_enable_n & !lane_n[lane]);
		end
	endgenerate

	// no lane selected means a read
	assign write_ind = |lane_mask;

	assign selects_ok = !select_primary_n & select_secondary_high & !select_tertiary_n;
	// processor strobe is ignored while the primary select is high
	assign proc_start = !proc_addr_strobe_n & !select_primary_n;
	// controller strobe is ignored while the processor strobe acts
	assign ctrl_start = !proc_start & !ctrl_addr_strobe_n;

	always_comb begin
		state_next = state_reg;
		seq_load    = 1'b0;
		seq_advance = 1'b0;

		state_next.sleep_sync = {state_reg.sleep_sync[SYNC_STAGES-2:0], sleep_request};
		state_next.mode_sync  = {state_reg.mode_sync[SYNC_STAGES-2:0], linear_burst};
		if (state_reg.sleep_sync[1] == state_reg.sleep_sync[2]) begin
			state_next.sleep_on = state_reg.sleep_sync[2];
		end
		if (state_reg.mode_sync[1] == state_reg.mode_sync[2]) begin
			state_next.linear_on = state_reg.mode_sync[2];
		end

		state_next.core_wr         = 1'b0;
		state_next.after_proc_read = 1'b0;

		if (state_reg.sleep_on) begin
			// pending accesses are dropped on entry
			state_next.cycle      = CYC_SLEEP;
			state_next.burst_open = 1'b0;
			state_next.reading    = 1'b0;
		end else if (proc_start) begin
			if (selects_ok) begin
				// write inputs ignored here
				state_next.cycle           = CYC_BEGIN_READ;
				state_next.addr            = address;
				state_next.burst_open      = 1'b1;
				state_next.after_proc_read = 1'b1;
				state_next.reading         = 1'b1;
				seq_load                   = 1'b1;
			end else begin
				state_next.cycle      = CYC_DESELECT;
				state_next.burst_open = 1'b0;
				state_next.reading    = 1'b0;
			end
		end else if (ctrl_start) begin
			if (!selects_ok) begin
				state_next.cycle      = CYC_DESELECT;
				state_next.burst_open = 1'b0;
				state_next.reading    = 1'b0;
			end else begin
				state_next.addr       = address;
				state_next.burst_open = 1'b1;
				seq_load              = 1'b1;
				if (write_ind) begin
					state_next.cycle   = CYC_BEGIN_WRITE;
					state_next.reading = 1'b0;
					state_next.core_wr = 1'b1;
				end else begin
					state_next.cycle   = CYC_BEGIN_READ;
					state_next.reading = 1'b1;
				end
			end
		end else if (state_reg.burst_open) begin
			if (write_ind) begin
				state_next.reading = 1'b0;
				state_next.core_wr = 1'b1;
				if (!burst_advance_n) begin
					state_next.cycle = CYC_CONTINUE_WRITE;
					seq_advance      = 1'b1;
				end else if (state_reg.after_proc_read) begin
					state_next.cycle = CYC_BEGIN_WRITE;
				end else begin
					state_next.cycle = CYC_SUSPEND_WRITE;
				end
			end else begin
				state_next.reading = 1'b1;
				if (!burst_advance_n) begin
					state_next.cycle = CYC_CONTINUE_READ;
					seq_advance      = 1'b1;
				end else begin
					state_next.cycle = CYC_SUSPEND_READ;
				end
			end
		end else begin
			state_next.cycle   = CYC_DESELECT;
			state_next.reading = 1'b0;
		end

		if (state_next.core_wr) begin
			// only the selected lanes reach the core
			state_next.lane_we = lane_mask;
			state_next.wdata   = data_in;
		end else begin
			state_next.lane_we = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg            <= '0;
			state_reg.sleep_sync <= SYNC_RESET;
			state_reg.mode_sync  <= SYNC_RESET;
			state_reg.sleep_on   <= SLEEP_RESET;
			state_reg.linear_on  <= LINEAR_RESET;
			state_reg.cycle      <= CYC_DESELECT;
		end else begin
			state_reg <= state_next;
		end
	end

	burst_sequencer u_burst (
		.clk         (clk),
		.reset       (reset),
		.load        (seq_load),
		.advance     (seq_advance),
		.linear_mode (state_reg.linear_on),
		.base        (address[BURST_BITS-1:0]),
		.seq         (seq_low)
	);

	// high bits held from the strobe, low bits from the sequencer
	assign core_addr    = {state_reg.addr[ADDR_W-1:BURST_BITS], seq_low};
	assign core_read    = state_reg.reading;
	assign core_write   = state_reg.core_wr;
	assign core_lane_we = state_reg.lane_we;
	assign core_wdata   = state_reg.wdata;
	assign cycle_type   = state_reg.cycle;
	assign sleeping     = state_reg.sleep_on;

	// output enable gates the drivers without any clock
	assign data_out = core_rdata;
	assign data_oe  = {DATA_W{state_reg.reading & !output_enable_n}};

endmodule : sram_cycle_control

// ### logic/sram_cycle_pkg.sv
// shared constants and types for the burst sram cycle control
package sram_cycle_pkg;

	// lane layout: eight data bits plus one parity bit per byte lane
	localparam int LANE_DATA_BITS   = 8;
	localparam int LANE_PARITY_BITS = 1;
	localparam int LANE_BITS        = LANE_DATA_BITS + LANE_PARITY_BITS;

	// the two organisations
	localparam int WIDE_LANES  = 4;
	localparam int NARROW_LANES = 2;
	localparam int WIDE_ADDR_W  = 19;
	localparam int NARROW_ADDR_W = 20;
	localparam int MAX_LANES    = 4;

	// burst counter
	localparam int BURST_BITS = 2;
	localparam logic [BURST_BITS-1:0] BURST_FIRST = 2'h0;
	localparam logic [BURST_BITS-1:0] BURST_STEP  = 2'h1;

	// pin synchroniser depth for sleep and burst mode
	localparam int SYNC_STAGES = 3;
	localparam logic [SYNC_STAGES-1:0] SYNC_RESET = 3'h0;

	// reset values
	localparam logic SLEEP_RESET  = 1'b0;
	localparam logic LINEAR_RESET = 1'b0;

	typedef enum logic [2:0] {
		CYC_DESELECT,
		CYC_BEGIN_READ,
		CYC_CONTINUE_READ,
		CYC_SUSPEND_READ,
		CYC_BEGIN_WRITE,
		CYC_CONTINUE_WRITE,
		CYC_SUSPEND_WRITE,
		CYC_SLEEP
	} cycle_t;

endpackage : sram_cycle_pkg

// ### tb/sram_core_model.sv
// behavioural memory core behind the cycle control
module sram_core_model
	import sram_cycle_pkg::*;
(
	input  wire logic        clk,
	input  wire logic [3:0]  addr,
	input  wire logic        write,
	input  wire logic [3:0]  lane_we,
	input  wire logic [35:0] wdata,
	output logic      [35:0] rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [35:0] mem [16];

	initial foreach (mem[i]) mem[i] = 36'h0_0000_0000;

	always @(posedge clk) begin
		for (int k = 0; k < 4; k++)
			if (write && lane_we[k]) mem[addr][k*9 +: 9] <= wdata[k*9 +: 9];
	end

	assign rdata = mem[addr];
endmodule : sram_core_model

// ### tb/sram_cycle_control_bench.sv
// self-checking bench for the sram cycle control
module sram_cycle_control_bench import sram_cycle_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, reset, sleep_request, linear_burst, output_enable_n;
	logic        select_primary_n, select_secondary_high, select_tertiary_n;
	logic        proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n, global_write_n, byte_write_enable_n;
	logic        lane_a_write_n, lane_b_write_n, lane_c_write_n, lane_d_write_n, core_read, core_write, sleeping;
	logic [18:0] address, core_addr;
	logic [35:0] data_in, data_out, data_oe, core_wdata, core_rdata;
	logic [3:0]  core_lane_we;
	cycle_t      cycle_type;
	int          error_cnt = 0, comparisons = 0, cycles = 0;

	sram_cycle_control u_sram_cycle_control (.clk, .reset, .sleep_request, .linear_burst, .output_enable_n,
		.select_primary_n, .select_secondary_high, .select_tertiary_n, .address, .proc_addr_strobe_n,
		.ctrl_addr_strobe_n, .burst_advance_n, .global_write_n, .byte_write_enable_n, .lane_a_write_n,
		.lane_b_write_n, .lane_c_write_n, .lane_d_write_n, .data_in, .data_out, .data_oe, .core_addr,
		.core_read, .core_write, .core_lane_we, .core_wdata, .core_rdata, .cycle_type, .sleeping);
	sram_core_model u_sram_core_model (.clk, .addr(core_addr[3:0]), .write(core_write), .lane_we(core_lane_we),
		.wdata(core_wdata), .rdata(core_rdata));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			error_cnt++;
			results();
		end
	end

	task automatic tick(input int n = 1);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic idle();
		{proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n, global_write_n, byte_write_enable_n} = 5'h1f;
		{lane_d_write_n, lane_c_write_n, lane_b_write_n, lane_a_write_n} = 4'hf;
		{select_primary_n, select_secondary_high, select_tertiary_n} = 3'h2;
	endtask : idle
	task automatic check_val(input logic [35:0] got, input logic [35:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : check_val
	task automatic check_cyc(input cycle_t got, input cycle_t exp);
		check_val(36'(got), 36'(exp));
	endtask : check_cyc

	task automatic test_write();
		idle();
		output_enable_n = 1'b1;
		{ctrl_addr_strobe_n, global_write_n, address, data_in} = {2'h0, 19'h0_0004, 36'h1_2345_6789};
		tick();
		check_cyc(cycle_type, CYC_BEGIN_WRITE);
		check_val(36'({core_write, core_lane_we}), 36'h1f);
		check_val(core_wdata, 36'h1_2345_6789);
		idle();
		{output_enable_n, global_write_n} = 2'h0;
		tick();
		check_cyc(cycle_type, CYC_SUSPEND_WRITE);
		check_val({data_oe[34:0], core_write}, 36'h0_0000_0001);
		burst_advance_n = 1'b0;
		tick();
		check_cyc(cycle_type, CYC_CONTINUE_WRITE);
		check_val(36'(core_addr), 36'h0_0005);
		$display("write burst test done");
	endtask : test_write

	task automatic test_lanes();
		output_enable_n = 1'b1;
		for (int m = 15; m >= 0; m--) begin
			idle();
			{ctrl_addr_strobe_n, byte_write_enable_n, address, data_in} = {2'h0, 19'h0_0009, {4{9'(m)}}};
			{lane_d_write_n, lane_c_write_n, lane_b_write_n, lane_a_write_n} = ~4'(m);
			tick();
			check_cyc(cycle_type, m == 0 ? CYC_BEGIN_READ : CYC_BEGIN_WRITE);
			check_val(36'(core_lane_we & {4{core_write}}), 36'(m));
		end
		{byte_write_enable_n, lane_a_write_n} = 2'h2;
		tick();
		check_cyc(cycle_type, CYC_BEGIN_READ);
		$display("lane mask test done");
	endtask : test_lanes

	task automatic test_read(input logic lin);
		// close the open burst before the mode pin moves, so no suspend sees the sequence change
		idle();
		{select_primary_n, ctrl_addr_strobe_n} = 2'h2;
		tick();
		check_cyc(cycle_type, CYC_DESELECT);
		linear_burst = lin;
		idle();
		tick(8);
		{output_enable_n, global_write_n, proc_addr_strobe_n, address} = {3'h0, 19'h1_2349};
		tick();
		check_cyc(cycle_type, CYC_BEGIN_READ);
		check_val(data_out, {9'h008, 9'h004, 9'h002, 9'h001});
		check_val(data_oe, 36'hf_ffff_ffff);
		idle();
		burst_advance_n = 1'b0;
		for (int k = 1; k < 4; k++) begin
			tick();
			check_cyc(cycle_type, CYC_CONTINUE_READ);
			check_val(36'(core_addr), 36'({17'h0_48d2, lin ? 2'(1 + k) : 2'(1 ^ k)}));
		end
		burst_advance_n = 1'b1;
		tick();
		check_cyc(cycle_type, CYC_SUSPEND_READ);
		check_val(36'(core_addr[1:0]), lin ? 36'h0 : 36'h2);
		output_enable_n = 1'b1;
		#1;
		check_val(data_oe, 36'h0);
		$display("read burst test done");
	endtask : test_read

	task automatic test_proc_write();
		idle();
		{proc_addr_strobe_n, global_write_n, address} = {2'h0, 19'h0_0003};
		tick();
		check_val(36'({core_write, core_read}), 36'h1);
		idle();
		global_write_n = 1'b0;
		tick();
		check_cyc(cycle_type, CYC_BEGIN_WRITE);
		check_val(36'({core_write, core_addr}), 36'h8_0003);
		$display("processor strobe write test done");
	endtask : test_proc_write

	task automatic test_deselect();
		logic [4:0] combo [5] = '{5'h1a, 5'h0d, 5'h01, 5'h0e, 5'h02};
		foreach (combo[i]) begin
			idle();
			global_write_n = 1'b0;
			{select_primary_n, select_secondary_high, select_tertiary_n, proc_addr_strobe_n,
				ctrl_addr_strobe_n} = combo[i];
			tick();
			check_cyc(cycle_type, CYC_DESELECT);
			check_val(36'({core_write, core_read}), 36'h0);
		end
		$display("deselect test done");
	endtask : test_deselect

	task automatic test_sleep();
		idle();
		sleep_request = 1'b1;
		tick(8);
		{proc_addr_strobe_n, ctrl_addr_strobe_n, global_write_n} = 3'h0;
		tick();
		check_val(36'({sleeping, core_write, core_read}), 36'h4);
		check_cyc(cycle_type, CYC_SLEEP);
		idle();
		select_primary_n = 1'b1;
		sleep_request = 1'b0;
		tick(8);
		check_val(36'(sleeping), 36'h0);
		$display("sleep test done");
	endtask : test_sleep

	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : results

	initial begin
		{reset, sleep_request, linear_burst, output_enable_n, address, data_in} = {4'h9, 19'h0, 36'h0};
		idle();
		tick(12);
		check_cyc(cycle_type, CYC_DESELECT);
		reset = 1'b0;
		test_write();
		test_lanes();
		test_read(1'b0);
		test_read(1'b1);
		test_proc_write();
		test_deselect();
		test_sleep();
		results();
	end
endmodule : sram_cycle_control_bench

// ### tb/sram_cycle_control_monitor.sv
// concurrent checks on the cycle control ports
module sram_cycle_control_monitor
	import sram_cycle_pkg::*;
#(
	parameter bit WIDE_ORG = 1'b1,
	parameter int ADDR_W   = WIDE_ADDR_W
) (
	input wire logic              clk,
	input wire logic              reset,
	input wire logic              sleep_request,
	input wire logic              output_enable_n,
	input wire logic              select_primary_n,
	input wire logic              proc_addr_strobe_n,
	input wire logic              ctrl_addr_strobe_n,
	input wire logic [(WIDE_ORG ? WIDE_LANES : NARROW_LANES)*LANE_BITS-1:0] data_oe,
	input wire logic [ADDR_W-1:0] core_addr,
	input wire logic              core_read,
	input wire logic              core_write,
	input wire cycle_t            cycle_type,
	input wire logic              sleeping
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	chk_sleep_cycle: assert property (sleeping |=> cycle_type == CYC_SLEEP)
		else $error("sleep cycle missing");
	chk_sleep_entry: assert property (sleep_request [*6] |-> sleeping)
		else $error("sleep not entered");
	chk_deselect_primary: assert property (!sleeping && select_primary_n && !ctrl_addr_strobe_n
		|=> cycle_type == CYC_DESELECT && !core_read && !core_write) else $error("no deselect");
	chk_proc_no_write: assert property (!sleeping && !select_primary_n && !proc_addr_strobe_n
		|=> !core_write) else $error("write on processor strobe");
	chk_oe_float: assert property (output_enable_n |-> data_oe == '0)
		else $error("driven with oe high");
	chk_oe_drive: assert property (core_read && !output_enable_n |-> &data_oe)
		else $error("read not driven");
	chk_write_mask: assert property (core_write |-> data_oe == '0)
		else $error("driven during write");
	chk_suspend_hold: assert property (cycle_type == CYC_SUSPEND_READ |-> $stable(core_addr))
		else $error("suspend moved address");
	chk_continue_step: assert property (cycle_type == CYC_CONTINUE_READ |->
		$stable(core_addr[ADDR_W-1:2]) && core_addr[1:0] != $past(core_addr[1:0])) else $error("bad burst step");
endmodule : sram_cycle_control_monitor

bind sram_cycle_control sram_cycle_control_monitor #(.WIDE_ORG(WIDE_ORG), .ADDR_W(ADDR_W))
	u_sram_cycle_control_monitor (.clk, .reset, .sleep_request, .output_enable_n, .select_primary_n,
	.proc_addr_strobe_n, .ctrl_addr_strobe_n, .data_oe, .core_addr, .core_read, .core_write, .cycle_type,
	.sleeping);
